// ### pin_mux_pkg.sv
// Purpose: shared types and constants for the operating-mode pin mux
// Assumes: all shared pins are sampled on clk
// Notes: mode pin is three-level, carried as a two-bit level code

package pin_mux_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int PERF_W = 4;

	// ****************************************
	// types
	// ****************************************
	// level seen on the mode pin; 2'b11 cannot occur on a real pin
	typedef enum logic [1:0] {
		LVL_LOW = 2'b00,
		LVL_HIGH = 2'b01,
		LVL_MID = 2'b10
	} level_t;

	typedef enum logic [1:0] {
		MODE_HW = 2'b00,
		MODE_STROBE = 2'b01,
		MODE_ENABLE = 2'b10,
		MODE_SERIAL = 2'b11
	} op_mode_t;

	// ****************************************
	// values after reset and idle levels
	// ****************************************
	localparam op_mode_t MODE_RST = MODE_HW;
	localparam level_t LEVEL_RST = LVL_LOW;
	localparam logic BIT_RST = 1'b0;
	localparam logic STROBE_N_RST = 1'b1;
	localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [PERF_W-1:0] PERF_RST = 4'h0;
	// undriven pins: data lines pulled low, response line pulled high
	localparam logic [DATA_W-1:0] BUS_IDLE = 8'h00;
	localparam logic RESP_IDLE = 1'b1;
	// bus-style pin level for each parallel style
	localparam logic STYLE_STROBE = 1'b0;
	localparam logic STYLE_ENABLE = 1'b1;

endpackage

// ### mux_pins_if.sv
// Purpose: shared pin group between the device end and the host end
// Assumes: enables are active low
// Notes: two-way lines are resolved here from the enables

`timescale 1ns/1ps

interface mux_pins_if;
	import pin_mux_pkg::*;

	// host driven pins
	level_t mode_level;
	logic [ADDR_W-1:0] addr_lines;
	logic code_style_pin;
	logic select_pin;
	logic dir_pin;
	logic strobe_a_pin;
	logic strobe_b_pin;
	// data lines, driven by either end
	logic [DATA_W-1:0] bus_host_o;
	logic bus_host_oe_n;
	logic [DATA_W-1:0] bus_dev_o;
	logic bus_dev_oe_n;
	logic [DATA_W-1:0] bus_lines;
	// response line, driven by the device only
	logic resp_o;
	logic resp_oe_n;
	logic resp_line;

	// device wins a clash so a misbehaving host cannot hide read data
	assign bus_lines = !bus_dev_oe_n ? bus_dev_o : (!bus_host_oe_n ? bus_host_o : BUS_IDLE);
	assign resp_line = !resp_oe_n ? resp_o : RESP_IDLE;

	modport dev (
		input mode_level, addr_lines, code_style_pin, select_pin,
		input dir_pin, strobe_a_pin, strobe_b_pin, bus_lines,
		output bus_dev_o, bus_dev_oe_n, resp_o, resp_oe_n
	);

	modport host (
		output mode_level, addr_lines, code_style_pin, select_pin,
		output dir_pin, strobe_a_pin, strobe_b_pin, bus_host_o, bus_host_oe_n,
		input bus_lines, resp_line
	);

endinterface // mux_pins_if

// ### pin_mux_device.sv
// Purpose: device end; decodes the mode straps and routes shared pins
// Assumes: pins synchronous to clk; straps held static while running
// Notes: every routed value is registered, one cycle of latency
//
// Notes on behaviour
// - mode pin low selects hardware mode
// - mode high: bus-style pin picks parallel style
// - mode at mid level selects serial interface
// - hardware mode pins carry static control selects
// - strobe style: address, data, strobes, acknowledge
// - enable style: address, data, enables, ready
// - serial: select, shift clock, data in, out

`timescale 1ns/1ps

module pin_mux_device import pin_mux_pkg::*; (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// shared pins
	mux_pins_if.dev pins,
	// decoded mode
	output op_mode_t op_mode,
	// hardware mode controls
	output logic hw_line_code,
	output logic hw_jitter_path,
	output logic [DATA_W-1:0] hw_line_return,
	output logic [PERF_W-1:0] hw_perf_mon,
	// parallel bus towards the register core
	output logic [ADDR_W-1:0] bus_addr,
	output logic [DATA_W-1:0] bus_wdata,
	output logic bus_cs_n,
	output logic bus_rw,
	output logic address_strobe_n,
	output logic data_strobe_n,
	output logic bus_rd_n,
	output logic bus_wr_n,
	output logic bus_ale,
	input wire logic [DATA_W-1:0] bus_rdata,
	input wire logic bus_rdata_oe,
	input wire logic bus_ack_n,
	input wire logic bus_rdy,
	// serial interface towards the register core
	output logic ser_cs_n,
	output logic ser_sclk,
	output logic shift_in,
	input wire logic shift_out
);

	// ****************************************
	// mode decode
	// ****************************************
	op_mode_t op_mode_r;
	op_mode_t op_mode_nxt;

	always_comb begin
		unique case (pins.mode_level)
			LVL_LOW: op_mode_nxt = MODE_HW;
			LVL_HIGH: op_mode_nxt = pins.code_style_pin ? MODE_ENABLE : MODE_STROBE;
			LVL_MID: op_mode_nxt = MODE_SERIAL;
			default: op_mode_nxt = MODE_HW;
		endcase
	end

	// decoded every cycle; a strap that moves while running takes effect here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op_mode_r <= MODE_RST;
		end else if (ce) begin
			op_mode_r <= op_mode_nxt;
		end
	end

	assign op_mode = op_mode_r;

	// ****************************************
	// hardware mode controls
	// ****************************************
	logic hw_line_code_r;
	logic hw_jitter_path_r;
	logic [DATA_W-1:0] hw_line_return_r;
	logic [PERF_W-1:0] hw_perf_mon_r;

	// outside hardware mode the selects fall back to their reset values
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hw_line_code_r <= BIT_RST;
			hw_jitter_path_r <= BIT_RST;
			hw_line_return_r <= DATA_RST;
			hw_perf_mon_r <= PERF_RST;
		end else if (ce) begin
			if (op_mode_r == MODE_HW) begin
				hw_line_code_r <= pins.code_style_pin;
				hw_jitter_path_r <= pins.select_pin;
				hw_line_return_r <= pins.bus_lines;
				hw_perf_mon_r <= pins.addr_lines[PERF_W-1:0];
			end else begin
				hw_line_code_r <= BIT_RST;
				hw_jitter_path_r <= BIT_RST;
				hw_line_return_r <= DATA_RST;
				hw_perf_mon_r <= PERF_RST;
			end
		end
	end

	assign hw_line_code = hw_line_code_r;
	assign hw_jitter_path = hw_jitter_path_r;
	assign hw_line_return = hw_line_return_r;
	assign hw_perf_mon = hw_perf_mon_r;

	// ****************************************
	// parallel address and data
	// ****************************************
	logic [ADDR_W-1:0] bus_addr_r;
	logic [DATA_W-1:0] bus_wdata_r;
	logic parallel;

	assign parallel = (op_mode_r == MODE_STROBE) || (op_mode_r == MODE_ENABLE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_addr_r <= ADDR_RST;
			bus_wdata_r <= DATA_RST;
		end else if (ce) begin
			if (parallel) begin
				bus_addr_r <= pins.addr_lines;
				bus_wdata_r <= pins.bus_lines;
			end else begin
				bus_addr_r <= ADDR_RST;
				bus_wdata_r <= DATA_RST;
			end
		end
	end

	assign bus_addr = bus_addr_r;
	assign bus_wdata = bus_wdata_r;

	// ****************************************
	// parallel controls
	// ****************************************
	logic bus_cs_n_r;
	logic bus_rw_r;
	logic address_strobe_n_r;
	logic data_strobe_n_r;
	logic bus_rd_n_r;
	logic bus_wr_n_r;
	logic bus_ale_r;

	// controls of the style not in use sit idle, so the core sees one style only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_cs_n_r <= STROBE_N_RST;
			bus_rw_r <= BIT_RST;
			address_strobe_n_r <= STROBE_N_RST;
			data_strobe_n_r <= STROBE_N_RST;
			bus_rd_n_r <= STROBE_N_RST;
			bus_wr_n_r <= STROBE_N_RST;
			bus_ale_r <= BIT_RST;
		end else if (ce) begin
			bus_cs_n_r <= parallel ? pins.select_pin : STROBE_N_RST;
			if (op_mode_r == MODE_STROBE) begin
				bus_rw_r <= pins.dir_pin;
				address_strobe_n_r <= pins.strobe_a_pin;
				data_strobe_n_r <= pins.strobe_b_pin;
			end else begin
				bus_rw_r <= BIT_RST;
				address_strobe_n_r <= STROBE_N_RST;
				data_strobe_n_r <= STROBE_N_RST;
			end
			if (op_mode_r == MODE_ENABLE) begin
				bus_rd_n_r <= pins.dir_pin;
				bus_ale_r <= pins.strobe_a_pin;
				bus_wr_n_r <= pins.strobe_b_pin;
			end else begin
				bus_rd_n_r <= STROBE_N_RST;
				bus_ale_r <= BIT_RST;
				bus_wr_n_r <= STROBE_N_RST;
			end
		end
	end

	assign bus_cs_n = bus_cs_n_r;
	assign bus_rw = bus_rw_r;
	assign address_strobe_n = address_strobe_n_r;
	assign data_strobe_n = data_strobe_n_r;
	assign bus_rd_n = bus_rd_n_r;
	assign bus_wr_n = bus_wr_n_r;
	assign bus_ale = bus_ale_r;

	// ****************************************
	// serial controls
	// ****************************************
	logic ser_cs_n_r;
	logic ser_sclk_r;
	logic shift_in_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ser_cs_n_r <= STROBE_N_RST;
			ser_sclk_r <= BIT_RST;
			shift_in_r <= BIT_RST;
		end else if (ce) begin
			if (op_mode_r == MODE_SERIAL) begin
				ser_cs_n_r <= pins.select_pin;
				ser_sclk_r <= pins.strobe_a_pin;
				shift_in_r <= pins.strobe_b_pin;
			end else begin
				ser_cs_n_r <= STROBE_N_RST;
				ser_sclk_r <= BIT_RST;
				shift_in_r <= BIT_RST;
			end
		end
	end

	assign ser_cs_n = ser_cs_n_r;
	assign ser_sclk = ser_sclk_r;
	assign shift_in = shift_in_r;

	// ****************************************
	// response pin
	// ****************************************
	logic resp_o_r;
	logic resp_oe_n_r;

	// released in hardware mode, and in serial mode while deselected
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			resp_o_r <= RESP_IDLE;
			resp_oe_n_r <= STROBE_N_RST;
		end else if (ce) begin
			unique case (op_mode_r)
				MODE_HW: begin
					resp_o_r <= RESP_IDLE;
					resp_oe_n_r <= 1'b1;
				end
				MODE_STROBE: begin
					resp_o_r <= bus_ack_n;
					resp_oe_n_r <= 1'b0;
				end
				MODE_ENABLE: begin
					resp_o_r <= bus_rdy;
					resp_oe_n_r <= 1'b0;
				end
				MODE_SERIAL: begin
					resp_o_r <= shift_out;
					resp_oe_n_r <= pins.select_pin;
				end
			endcase
		end
	end

	assign pins.resp_o = resp_o_r;
	assign pins.resp_oe_n = resp_oe_n_r;

	// ****************************************
	// data line drive
	// ****************************************
	logic [DATA_W-1:0] bus_dev_o_r;
	logic bus_dev_oe_n_r;
	logic read_phase;

	// drive only inside a read cycle, so a core glitch cannot fight a host write
	always_comb begin
		read_phase = 1'b0;
		if (op_mode_r == MODE_STROBE) begin
			read_phase = !pins.select_pin && pins.dir_pin && !pins.strobe_b_pin;
		end else if (op_mode_r == MODE_ENABLE) begin
			read_phase = !pins.select_pin && !pins.dir_pin;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_dev_o_r <= DATA_RST;
			bus_dev_oe_n_r <= STROBE_N_RST;
		end else if (ce) begin
			bus_dev_o_r <= bus_rdata;
			bus_dev_oe_n_r <= !(read_phase && bus_rdata_oe);
		end
	end

	assign pins.bus_dev_o = bus_dev_o_r;
	assign pins.bus_dev_oe_n = bus_dev_oe_n_r;

endmodule // pin_mux_device

// ### pin_mux_host.sv
// Purpose: host end; straps the mode and drives shared pins per mode
// Assumes: cfg_mode settled at reset release
// Notes: mode is captured once, later cfg_mode changes are ignored

`timescale 1ns/1ps

module pin_mux_host import pin_mux_pkg::*; (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// shared pins
	mux_pins_if.host pins,
	// strap choice
	input wire op_mode_t cfg_mode,
	output op_mode_t mode_held,
	// hardware mode settings
	input wire logic hw_line_code,
	input wire logic hw_jitter_path,
	input wire logic [DATA_W-1:0] hw_line_return,
	input wire logic [PERF_W-1:0] hw_perf_mon,
	// parallel bus from the processor
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [DATA_W-1:0] bus_wdata,
	input wire logic bus_cs_n,
	input wire logic bus_rw,
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic bus_rd_n,
	input wire logic bus_wr_n,
	input wire logic bus_ale,
	output logic [DATA_W-1:0] bus_rdata,
	output logic bus_ack_n,
	output logic bus_rdy,
	// serial interface from the processor
	input wire logic ser_cs_n,
	input wire logic ser_sclk,
	input wire logic shift_in,
	output logic shift_out
);

	// ****************************************
	// strap capture
	// ****************************************
	op_mode_t mode_r;
	logic taken_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_r <= MODE_RST;
			taken_r <= 1'b0;
		end else if (ce && !taken_r) begin
			mode_r <= cfg_mode;
			taken_r <= 1'b1;
		end
	end

	assign mode_held = mode_r;

	// ****************************************
	// pin drive
	// ****************************************
	level_t level_r;
	logic [ADDR_W-1:0] addr_r;
	logic code_style_r;
	logic select_r;
	logic dir_r;
	logic strobe_a_r;
	logic strobe_b_r;
	logic [DATA_W-1:0] bus_o_r;
	logic bus_oe_n_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level_r <= LEVEL_RST;
			addr_r <= ADDR_RST;
			code_style_r <= BIT_RST;
			select_r <= BIT_RST;
			dir_r <= BIT_RST;
			strobe_a_r <= BIT_RST;
			strobe_b_r <= BIT_RST;
			bus_o_r <= DATA_RST;
			bus_oe_n_r <= STROBE_N_RST;
		end else if (ce) begin
			unique case (mode_r)
				MODE_HW: begin
					level_r <= LVL_LOW;
					addr_r <= {1'b0, hw_perf_mon};
					code_style_r <= hw_line_code;
					select_r <= hw_jitter_path;
					dir_r <= 1'b0;
					strobe_a_r <= 1'b0;
					strobe_b_r <= 1'b0;
					bus_o_r <= hw_line_return;
					bus_oe_n_r <= 1'b0;
				end
				MODE_STROBE: begin
					level_r <= LVL_HIGH;
					addr_r <= bus_addr;
					code_style_r <= STYLE_STROBE;
					select_r <= bus_cs_n;
					dir_r <= bus_rw;
					strobe_a_r <= address_strobe_n;
					strobe_b_r <= data_strobe_n;
					bus_o_r <= bus_wdata;
					bus_oe_n_r <= !(!bus_cs_n && !bus_rw);
				end
				MODE_ENABLE: begin
					level_r <= LVL_HIGH;
					addr_r <= bus_addr;
					code_style_r <= STYLE_ENABLE;
					select_r <= bus_cs_n;
					dir_r <= bus_rd_n;
					strobe_a_r <= bus_ale;
					strobe_b_r <= bus_wr_n;
					bus_o_r <= bus_wdata;
					bus_oe_n_r <= !(!bus_cs_n && !bus_wr_n);
				end
				MODE_SERIAL: begin
					level_r <= LVL_MID;
					addr_r <= ADDR_RST;
					code_style_r <= BIT_RST;
					select_r <= ser_cs_n;
					dir_r <= BIT_RST;
					strobe_a_r <= ser_sclk;
					strobe_b_r <= shift_in;
					bus_o_r <= DATA_RST;
					bus_oe_n_r <= 1'b0;
				end
			endcase
		end
	end

	assign pins.mode_level = level_r;
	assign pins.addr_lines = addr_r;
	assign pins.code_style_pin = code_style_r;
	assign pins.select_pin = select_r;
	assign pins.dir_pin = dir_r;
	assign pins.strobe_a_pin = strobe_a_r;
	assign pins.strobe_b_pin = strobe_b_r;
	assign pins.bus_host_o = bus_o_r;
	assign pins.bus_host_oe_n = bus_oe_n_r;

	// ****************************************
	// responses back to the processor
	// ****************************************
	logic [DATA_W-1:0] bus_rdata_r;
	logic bus_ack_n_r;
	logic bus_rdy_r;
	logic shift_out_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_rdata_r <= DATA_RST;
			bus_ack_n_r <= STROBE_N_RST;
			bus_rdy_r <= BIT_RST;
			shift_out_r <= BIT_RST;
		end else if (ce) begin
			bus_rdata_r <= pins.bus_lines;
			bus_ack_n_r <= (mode_r == MODE_STROBE) ? pins.resp_line : STROBE_N_RST;
			bus_rdy_r <= (mode_r == MODE_ENABLE) ? pins.resp_line : BIT_RST;
			shift_out_r <= (mode_r == MODE_SERIAL) ? pins.resp_line : BIT_RST;
		end
	end

	assign bus_rdata = bus_rdata_r;
	assign bus_ack_n = bus_ack_n_r;
	assign bus_rdy = bus_rdy_r;
	assign shift_out = shift_out_r;

endmodule // pin_mux_host

// ### pin_mux_properties.sv
// Purpose: pin-level assertions for the mode pin mux
// Assumes: straps held static between resets
// Notes: device decode is seen only through pin behaviour

`timescale 1ns/1ps

module pin_mux_properties import pin_mux_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host driven pins
	input wire level_t mode_level,
	input wire logic [ADDR_W-1:0] addr_lines,
	input wire logic code_style_pin,
	input wire logic select_pin,
	input wire logic dir_pin,
	input wire logic strobe_a_pin,
	input wire logic strobe_b_pin,
	input wire logic [DATA_W-1:0] bus_host_o,
	input wire logic bus_host_oe_n,
	// device driven pins
	input wire logic bus_dev_oe_n,
	input wire logic resp_oe_n
);

	// ****************************************
	// sequences
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// three cycles deep so the registered mode has caught up
	sequence hw_settled;
		(mode_level == LVL_LOW) [*3];
	endsequence
	sequence par_settled;
		(mode_level == LVL_HIGH) [*3];
	endsequence
	sequence strobe_settled;
		(mode_level == LVL_HIGH && code_style_pin == STYLE_STROBE) [*3];
	endsequence
	sequence enable_settled;
		(mode_level == LVL_HIGH && code_style_pin == STYLE_ENABLE) [*3];
	endsequence
	sequence serial_settled;
		(mode_level == LVL_MID) [*3];
	endsequence

	// ****************************************
	// assertions
	// ****************************************
	chk_hw_resp_free: assert property (hw_settled |-> resp_oe_n)
		else $error("response pin driven in hardware mode");
	chk_hw_data_free: assert property (hw_settled |-> bus_dev_oe_n)
		else $error("data lines driven by device in hardware mode");
	chk_hw_pins_ground: assert property (mode_level == LVL_LOW |->
		!addr_lines[4] && !dir_pin && !strobe_a_pin && !strobe_b_pin)
		else $error("grounded pins high in hardware mode");
	chk_serial_ground: assert property (mode_level == LVL_MID |->
		!bus_host_oe_n && bus_host_o == 8'h00 && addr_lines == 5'h00 && !dir_pin && !code_style_pin)
		else $error("serial mode pins not grounded");
	chk_serial_resp: assert property (serial_settled |-> resp_oe_n == $past(select_pin))
		else $error("serial output drive does not follow select");
	chk_strobe_read: assert property (strobe_settled ##0
		!(!select_pin && dir_pin && !strobe_b_pin) |=> bus_dev_oe_n)
		else $error("device drives data outside a strobe read");
	chk_enable_read: assert property (enable_settled ##0
		!(!select_pin && !dir_pin) |=> bus_dev_oe_n)
		else $error("device drives data outside an enable read");
	chk_par_resp: assert property (par_settled |-> !resp_oe_n)
		else $error("response pin released in parallel mode");

endmodule // pin_mux_properties

// ### test_operating_mode_pin_mux.sv
// Purpose: both ends of the pin mux joined, driven through each mode
// Assumes: one registered hop at each end, in each direction
// Notes: a mode change needs a reset, as the host straps once

`timescale 1ns/1ps

module test_operating_mode_pin_mux import pin_mux_pkg::*;;

	// ****************************************
	// signals
	// ****************************************
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
	op_mode_t cfg_mode = MODE_HW, mode_held, op_mode_dv;
	logic hw_line_code_hs = 1'b0, hw_jitter_path_hs = 1'b0, hw_line_code_dv, hw_jitter_path_dv;
	logic [7:0] hw_line_return_hs = 8'h00, hw_line_return_dv;
	logic [3:0] hw_perf_mon_hs = 4'h0, hw_perf_mon_dv;
	logic [4:0] bus_addr_hs = 5'h00, bus_addr_dv;
	logic [7:0] bus_wdata_hs = 8'h00, bus_wdata_dv, bus_rdata_hs, bus_rdata_dv = 8'h00;
	logic bus_cs_n_hs = 1'b1, bus_rw_hs = 1'b0, address_strobe_n_hs = 1'b1, data_strobe_n_hs = 1'b1;
	logic bus_rd_n_hs = 1'b1, bus_wr_n_hs = 1'b1, bus_ale_hs = 1'b0;
	logic bus_cs_n_dv, bus_rw_dv, address_strobe_n_dv, data_strobe_n_dv;
	logic bus_rd_n_dv, bus_wr_n_dv, bus_ale_dv;
	logic bus_rdata_oe_dv = 1'b0, bus_ack_n_dv = 1'b1, bus_rdy_dv = 1'b0, bus_ack_n_hs, bus_rdy_hs;
	logic ser_cs_n_hs = 1'b1, ser_sclk_hs = 1'b0, shift_in_hs = 1'b0, shift_out_dv = 1'b0;
	logic ser_cs_n_dv, ser_sclk_dv, shift_in_dv, shift_out_hs;
	int num_errors = 0, total_checks = 0, cycles = 0;

	always #2.5 clk = ~clk;

	// ****************************************
	// ends and checker
	// ****************************************
	mux_pins_if pins();

	pin_mux_host u_pin_mux_host (.clk(clk), .rst(rst), .ce(ce), .pins(pins),
		.cfg_mode(cfg_mode), .mode_held(mode_held), .hw_line_code(hw_line_code_hs),
		.hw_jitter_path(hw_jitter_path_hs), .hw_line_return(hw_line_return_hs),
		.hw_perf_mon(hw_perf_mon_hs), .bus_addr(bus_addr_hs), .bus_wdata(bus_wdata_hs),
		.bus_cs_n(bus_cs_n_hs), .bus_rw(bus_rw_hs), .address_strobe_n(address_strobe_n_hs),
		.data_strobe_n(data_strobe_n_hs), .bus_rd_n(bus_rd_n_hs), .bus_wr_n(bus_wr_n_hs),
		.bus_ale(bus_ale_hs), .bus_rdata(bus_rdata_hs), .bus_ack_n(bus_ack_n_hs),
		.bus_rdy(bus_rdy_hs), .ser_cs_n(ser_cs_n_hs), .ser_sclk(ser_sclk_hs),
		.shift_in(shift_in_hs), .shift_out(shift_out_hs));

	pin_mux_device u_pin_mux_device (.clk(clk), .rst(rst), .ce(ce), .pins(pins),
		.op_mode(op_mode_dv), .hw_line_code(hw_line_code_dv), .hw_jitter_path(hw_jitter_path_dv),
		.hw_line_return(hw_line_return_dv), .hw_perf_mon(hw_perf_mon_dv),
		.bus_addr(bus_addr_dv), .bus_wdata(bus_wdata_dv), .bus_cs_n(bus_cs_n_dv),
		.bus_rw(bus_rw_dv), .address_strobe_n(address_strobe_n_dv),
		.data_strobe_n(data_strobe_n_dv), .bus_rd_n(bus_rd_n_dv), .bus_wr_n(bus_wr_n_dv),
		.bus_ale(bus_ale_dv), .bus_rdata(bus_rdata_dv), .bus_rdata_oe(bus_rdata_oe_dv),
		.bus_ack_n(bus_ack_n_dv), .bus_rdy(bus_rdy_dv), .ser_cs_n(ser_cs_n_dv),
		.ser_sclk(ser_sclk_dv), .shift_in(shift_in_dv), .shift_out(shift_out_dv));

	pin_mux_properties u_pin_mux_properties (.clk(clk), .rst(rst),
		.mode_level(pins.mode_level), .addr_lines(pins.addr_lines),
		.code_style_pin(pins.code_style_pin), .select_pin(pins.select_pin),
		.dir_pin(pins.dir_pin), .strobe_a_pin(pins.strobe_a_pin),
		.strobe_b_pin(pins.strobe_b_pin), .bus_host_o(pins.bus_host_o),
		.bus_host_oe_n(pins.bus_host_oe_n), .bus_dev_oe_n(pins.bus_dev_oe_n),
		.resp_oe_n(pins.resp_oe_n));

	// ****************************************
	// tasks
	// ****************************************
	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_mode(input op_mode_t got, input op_mode_t exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected mode at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// two registered hops each way, plus a spare edge
	task automatic settle();
		repeat (5) @(posedge clk);
		#1;
	endtask

	// straps change only under reset, the host captures once
	task automatic start_mode(input op_mode_t m);
		@(posedge clk);
		rst <= 1'b1;
		cfg_mode <= m;
		{bus_cs_n_hs, bus_rd_n_hs, bus_wr_n_hs, ser_cs_n_hs, bus_ack_n_dv} <= 5'h1F;
		{bus_rw_hs, bus_ale_hs, bus_rdata_oe_dv, bus_rdy_dv} <= 4'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle();
		check_mode(op_mode_dv, m);
		check_mode(mode_held, m);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			num_errors++;
			final_report();
		end
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		start_mode(MODE_HW);
		@(posedge clk);
		hw_line_code_hs <= 1'b1;
		hw_jitter_path_hs <= 1'b1;
		hw_line_return_hs <= 8'hA5;
		hw_perf_mon_hs <= 4'h9;
		settle();
		check_val(8'(hw_line_code_dv), 8'h01);
		check_val(8'(hw_jitter_path_dv), 8'h01);
		check_val(hw_line_return_dv, 8'hA5);
		check_val(8'(hw_perf_mon_dv), 8'h09);
		check_val(bus_wdata_dv, 8'h00);
		check_val(8'(bus_cs_n_dv), 8'h01);
		@(posedge clk);
		hw_line_code_hs <= 1'b0;
		hw_line_return_hs <= 8'h5A;
		settle();
		check_mode(op_mode_dv, MODE_HW);
		check_val(8'(hw_line_code_dv), 8'h00);
		check_val(hw_line_return_dv, 8'h5A);
		// ce low must freeze both ends, so a new setting waits for ce
		@(posedge clk);
		ce <= 1'b0;
		hw_line_return_hs <= 8'h3C;
		settle();
		check_val(hw_line_return_dv, 8'h5A);
		@(posedge clk);
		ce <= 1'b1;
		settle();
		check_val(hw_line_return_dv, 8'h3C);

		start_mode(MODE_STROBE);
		@(posedge clk);
		bus_addr_hs <= 5'h13;
		bus_wdata_hs <= 8'h3C;
		bus_cs_n_hs <= 1'b0;
		address_strobe_n_hs <= 1'b0;
		data_strobe_n_hs <= 1'b0;
		settle();
		check_val(8'(bus_addr_dv), 8'h13);
		check_val(bus_wdata_dv, 8'h3C);
		check_val({4'h0, bus_cs_n_dv, bus_rw_dv, address_strobe_n_dv, data_strobe_n_dv}, 8'h00);
		check_val({6'h00, bus_rd_n_dv, bus_ale_dv}, 8'h02);
		check_val(hw_line_return_dv, 8'h00);
		@(posedge clk);
		bus_rw_hs <= 1'b1;
		bus_rdata_dv <= 8'hC3;
		bus_rdata_oe_dv <= 1'b1;
		bus_ack_n_dv <= 1'b0;
		settle();
		check_val(bus_rdata_hs, 8'hC3);
		check_val(8'(bus_ack_n_hs), 8'h00);
		check_val({6'h00, bus_rw_dv, data_strobe_n_dv}, 8'h02);

		start_mode(MODE_ENABLE);
		@(posedge clk);
		bus_addr_hs <= 5'h0A;
		bus_wdata_hs <= 8'h96;
		bus_cs_n_hs <= 1'b0;
		bus_wr_n_hs <= 1'b0;
		bus_ale_hs <= 1'b1;
		settle();
		check_val(8'(bus_addr_dv), 8'h0A);
		check_val(bus_wdata_dv, 8'h96);
		check_val({4'h0, bus_cs_n_dv, bus_rd_n_dv, bus_wr_n_dv, bus_ale_dv}, 8'h05);
		check_val(8'(address_strobe_n_dv), 8'h01);
		@(posedge clk);
		bus_wr_n_hs <= 1'b1;
		bus_rd_n_hs <= 1'b0;
		bus_rdata_dv <= 8'h69;
		bus_rdata_oe_dv <= 1'b1;
		bus_rdy_dv <= 1'b1;
		settle();
		check_val(bus_rdata_hs, 8'h69);
		check_val(8'(bus_rdy_hs), 8'h01);

		start_mode(MODE_SERIAL);
		@(posedge clk);
		ser_cs_n_hs <= 1'b0;
		ser_sclk_hs <= 1'b1;
		shift_in_hs <= 1'b1;
		shift_out_dv <= 1'b1;
		bus_wdata_hs <= 8'hFF;
		settle();
		check_val({5'h00, ser_cs_n_dv, ser_sclk_dv, shift_in_dv}, 8'h03);
		check_val(8'(shift_out_hs), 8'h01);
		check_val(bus_rdata_hs, 8'h00);
		check_val(8'(bus_addr_dv), 8'h00);
		@(posedge clk);
		shift_in_hs <= 1'b0;
		shift_out_dv <= 1'b0;
		settle();
		check_val(8'(shift_in_dv), 8'h00);
		check_val(8'(shift_out_hs), 8'h00);
		final_report();
	end

endmodule // test_operating_mode_pin_mux
